// ### logic/usbdlp_regs.vh
/*
  register indices, field positions, reset values and timing figures of the
  usb device link power block.
  assumes a 100 MHz register clock and an apb bus with 32-bit data.
*/
// Operation
// - feedback endpoint shares a number with data endpoints, opposite direction
// - each endpoint half keeps its own packet size and transfer type
// - pad low power in idle state, fully active in active state
// - bus suspend raises suspend flag and idles the pad
// - non-idle bus while suspended raises wake flag and wakes the pad
// - pad idle while disabled or detached; active once enabled and attached
// - upstream resume is the only self-started signalling, after host permits
// - upstream resume only after a bus suspend set the suspend flag; the code also allows it from lpm sleep without the flag
// - remote wake bit drives resume once bus inactive for 5 ms
// - sending upstream resume sets wake flag, clears suspend flag
// - remote wake bit clears when upstream resume finishes
// - end of host rebroadcast resume sets end-of-resume flag
// - remote wake set during downstream resume is cleared and ignored
// - lpm on enabled endpoint answered with the selected handshake
// - answered lpm writes besl, remote wake, link state to descriptor
// - lpm ack sets lpm suspend flag, transceiver suspends 9 us later
// - lpm nyet sets not-yet flag; interrupt only when enabled
// - lpm stall or no handshake sets nothing, transaction ignored
// - lpm sleep exits like suspend, with shorter remote wake drive
// - wake interrupt is produced without a running clock
// - enable write reads back at once, busy until crossed over
`ifndef USBDLP_REGS_VH
`define USBDLP_REGS_VH

// register indices; byte address is four times the index
`define USBDLP_IDX_CONTROL_MAIN 10'h000
`define USBDLP_IDX_SYNC_BUSY 10'h002
`define USBDLP_IDX_MEM_PRIORITY 10'h003
`define USBDLP_IDX_DEVICE_CONTROL 10'h008
`define USBDLP_IDX_LINK_STATE 10'h00D
`define USBDLP_IDX_IRQ_ENABLE_CLR 10'h014
`define USBDLP_IDX_IRQ_ENABLE_SET 10'h016
`define USBDLP_IDX_IRQ_FLAGS 10'h01C
`define USBDLP_IDX_DESC_BASE 10'h024
`define USBDLP_IDX_PAD_TRIM 10'h028
`define USBDLP_IDX_EP_CFG 10'h040

// control_main fields
`define USBDLP_CM_SOFT_RESET 0
`define USBDLP_CM_ENABLE 1
`define USBDLP_CM_KEEP_RUNNING 2
// device_control fields
`define USBDLP_DC_DETACH 0
`define USBDLP_DC_REMOTE_WAKE 1
`define USBDLP_DC_HSK_LSB 2
// irq flag positions
`define USBDLP_F_SUSPEND 0
`define USBDLP_F_WAKEUP 1
`define USBDLP_F_END_OF_RESUME_FLAG 2
`define USBDLP_F_LPM_SUSP 3
`define USBDLP_F_LPM_NYET 4
// lpm handshake select codes
`define USBDLP_HSK_NONE 2'h0
`define USBDLP_HSK_ACK 2'h1
`define USBDLP_HSK_NYET 2'h2
`define USBDLP_HSK_STALL 2'h3

// reset values
`define USBDLP_RST_MEM_PRIORITY 4'hF
`define USBDLP_RST_DETACH 1'b1
`define USBDLP_RST_PAD_TRIM 16'h0000
`define USBDLP_RST_DESC_BASE 32'h0000_0000

// descriptor layout of the link power word
`define USBDLP_DESC_EP_STRIDE_SH 5
`define USBDLP_DESC_LPW_OFFSET 32'h0000_0008

// timing
`define USBDLP_CLK_PERIOD_NS 10
`define USBDLP_LPM_SUSP_DELAY_NS 9000
`define USBDLP_RWK_IDLE_MS 5

`endif

// ### logic/usbdlp_sync.v
/*
  three-flop synchroniser for pin levels, one generate lane per bit.
  assumes the inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module usbdlp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire ref_clk, // register clock
  input wire reset, // async reset, active high
  input wire [W-1:0] pin_in, // raw pin levels
  output wire [W-1:0] level_out // filtered level
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // level changes once second and third stage agree
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          s1_q <= RST_VAL[i];
          s2_q <= RST_VAL[i];
          s3_q <= RST_VAL[i];
          lvl_q <= RST_VAL[i];
        end else begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign level_out[i] = lvl_q;
    end
  endgenerate
endmodule

// ### logic/usbdlp_timer.v
/*
  down counter used for the lpm suspend delay and the resume drive time.
  assumes load is a one-cycle pulse; a new load restarts the count.
*/
`timescale 1ns/1ps
module usbdlp_timer (
  input wire ref_clk, // register clock
  input wire reset, // async reset, active high
  input wire load, // start pulse
  input wire [19:0] load_val, // cycles to run, at least one
  output wire busy, // counting
  output reg done // one-cycle pulse at expiry
);
  reg [19:0] cnt_q;

  assign busy = (cnt_q != 20'h0_0000);

  // count down, pulse done on the last cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 20'h0_0000;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == 20'h0_0001);
      if (busy) begin
        cnt_q <= cnt_q - 20'h0_0001;
      end
    end
  end
endmodule

// ### logic/usbdlp_link_pm.v
/*
  usb device link power block: apb register file, suspend and resume
  detection, pad state, remote wake and lpm handling.
  assumes bus line levels arrive on pins from the transceiver, lpm tokens
  come from the protocol engine on ref_clk, and descriptor writes go to a
  memory port with a ready handshake.
*/
`timescale 1ns/1ps
`include "usbdlp_regs.vh"
module usbdlp_link_pm #(
  parameter SUSPEND_CYCLES = 300000, // 3 ms bus idle means suspend
  parameter RWK_IDLE_CYCLES = `USBDLP_RWK_IDLE_MS * 100000, // 5 ms at 100 MHz
  parameter RESUME_DRIVE_CYCLES = 200000, // upstream resume drive, 2 ms
  parameter LPM_DRIVE_CYCLES = 5000 // shorter drive out of lpm sleep
) (
  input wire ref_clk, // 100 MHz clock
  input wire reset, // async reset, active high
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error, unmapped address
  input wire bus_idle_pin, // line in idle j state
  input wire bus_reset_pin, // line held in reset
  input wire lpm_rx_valid, // lpm token received, pulse
  input wire [2:0] lpm_rx_ep, // addressed endpoint
  input wire [3:0] lpm_rx_besl, // best effort latency
  input wire lpm_rx_remote_wake, // host permits remote wake
  input wire [3:0] lpm_rx_link_state, // requested link state
  output wire [1:0] lpm_hs_code, // handshake to return
  output wire lpm_hs_valid, // handshake code applies now
  output reg desc_wr_valid, // descriptor write request
  output reg [31:0] desc_wr_addr, // descriptor byte address
  output reg [15:0] desc_wr_data, // link power word
  input wire desc_wr_ready, // memory took the write
  output wire pad_active, // pad fully on, else low power
  output wire resume_k_o, // resume k level out
  output wire resume_k_oe, // resume drive enable
  output wire wake_async, // clockless wake request
  output wire irq, // masked flag interrupt
  output wire core_enable, // enable as seen by the core
  output wire keep_running_asleep, // usb clock kept in standby
  output wire [3:0] mem_priority, // data and config priority
  output wire [15:0] pad_trim, // pad calibration
  output wire [127:0] ep_cfg_flat // per endpoint type and size
);
  // ------------------------------------------------------------
  // link states
  // ------------------------------------------------------------
  localparam [6:0] ST_OFF = 7'h01;
  localparam [6:0] ST_ON = 7'h02;
  localparam [6:0] ST_SUSPEND = 7'h04;
  localparam [6:0] ST_SLEEP = 7'h08;
  localparam [6:0] ST_DNRESUME = 7'h10;
  localparam [6:0] ST_UPRESUME = 7'h20;
  localparam [6:0] ST_RESET = 7'h40;
  localparam [19:0] LPM_DELAY = `USBDLP_LPM_SUSP_DELAY_NS / `USBDLP_CLK_PERIOD_NS;

  reg enable_q;
  reg soft_reset_q;
  reg keep_run_q;
  reg [3:0] qos_q;
  reg [31:0] desc_base_q;
  reg [15:0] pad_trim_q;
  reg detach_q;
  reg rwr_q;
  reg [1:0] hsk_q;
  reg [4:0] flags_q;
  reg [4:0] irq_en_q;
  reg [15:0] ep_cfg_q [0:7];
  reg en_mid_q;
  reg en_core_q;
  reg [31:0] prdata_q;
  reg err_q;
  reg [6:0] state_q;
  reg [6:0] state_d;
  reg [19:0] idle_cnt_q;
  reg lpm_wait_q;
  reg set_susp;
  reg set_wake;
  reg clr_susp;
  reg set_end_of_resume_flag;
  reg rwr_done;
  reg tmr_load;
  reg [19:0] tmr_val;
  reg [31:0] rd_d;
  reg hit_d;
  wire idle_s;
  wire rst_s;
  wire tmr_done;
  wire [9:0] idx;
  wire acc;
  wire wr;
  wire soft_clr;
  wire lpm_ep_on;
  wire lpm_take;
  wire lpm_ack;
  wire lpm_nyet;
  wire rwr_wr;
  wire [4:0] hw_set;
  wire [4:0] w1c;

  // ------------------------------------------------------------
  // pin synchronisers and timer
  // ------------------------------------------------------------
  usbdlp_sync #(
    .W(2),
    .RST_VAL(2'b01)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in({bus_reset_pin, bus_idle_pin}),
    .level_out({rst_s, idle_s})
  );

  usbdlp_timer u_tmr (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(),
    .done(tmr_done)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign idx = paddr[11:2];
  assign acc = psel & penable;
  assign wr = acc & pwrite & hit_d;
  assign pready = acc;
  assign pslverr = acc & err_q;
  assign prdata = prdata_q;
  assign soft_clr = soft_reset_q;
  assign rwr_wr = wr & (idx == `USBDLP_IDX_DEVICE_CONTROL) & pwdata[`USBDLP_DC_REMOTE_WAKE];
  assign w1c = (wr & (idx == `USBDLP_IDX_IRQ_FLAGS)) ? pwdata[4:0] : 5'h00;

  // read mux and address check
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = (paddr[1:0] == 2'h0);
    if (idx >= `USBDLP_IDX_EP_CFG && idx < `USBDLP_IDX_EP_CFG + 10'h008) begin
      rd_d = {16'h0000, ep_cfg_q[idx[2:0]]};
    end else begin
      case (idx)
        `USBDLP_IDX_CONTROL_MAIN: rd_d = {29'h0000_0000, keep_run_q, enable_q, soft_reset_q};
        `USBDLP_IDX_SYNC_BUSY: rd_d = {30'h0000_0000, enable_q != en_core_q, soft_reset_q};
        `USBDLP_IDX_MEM_PRIORITY: rd_d = {28'h000_0000, qos_q};
        `USBDLP_IDX_DEVICE_CONTROL: rd_d = {28'h000_0000, hsk_q, rwr_q, detach_q};
        `USBDLP_IDX_LINK_STATE: rd_d = {25'h000_0000, state_q};
        `USBDLP_IDX_IRQ_ENABLE_CLR: rd_d = {27'h000_0000, irq_en_q};
        `USBDLP_IDX_IRQ_ENABLE_SET: rd_d = {27'h000_0000, irq_en_q};
        `USBDLP_IDX_IRQ_FLAGS: rd_d = {27'h000_0000, flags_q};
        `USBDLP_IDX_DESC_BASE: rd_d = desc_base_q;
        `USBDLP_IDX_PAD_TRIM: rd_d = {16'h0000, pad_trim_q};
        default: hit_d = 1'b0;
      endcase
    end
  end

  // read data and error latched in the setup cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel & ~penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      err_q <= ~hit_d;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // soft reset wins over every other field of the same write
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b0;
      soft_reset_q <= 1'b0;
      keep_run_q <= 1'b0;
      qos_q <= `USBDLP_RST_MEM_PRIORITY;
      desc_base_q <= `USBDLP_RST_DESC_BASE;
      pad_trim_q <= `USBDLP_RST_PAD_TRIM;
      detach_q <= `USBDLP_RST_DETACH;
      hsk_q <= `USBDLP_HSK_NONE;
      irq_en_q <= 5'h00;
    end else if (soft_clr) begin
      enable_q <= 1'b0;
      soft_reset_q <= 1'b0;
      keep_run_q <= 1'b0;
      qos_q <= `USBDLP_RST_MEM_PRIORITY;
      desc_base_q <= `USBDLP_RST_DESC_BASE;
      pad_trim_q <= `USBDLP_RST_PAD_TRIM;
      detach_q <= `USBDLP_RST_DETACH;
      hsk_q <= `USBDLP_HSK_NONE;
      irq_en_q <= 5'h00;
    end else if (wr) begin
      case (idx)
        `USBDLP_IDX_CONTROL_MAIN: begin
          if (pwdata[`USBDLP_CM_SOFT_RESET]) begin
            soft_reset_q <= 1'b1;
          end else begin
            enable_q <= pwdata[`USBDLP_CM_ENABLE];
            keep_run_q <= pwdata[`USBDLP_CM_KEEP_RUNNING];
          end
        end
        `USBDLP_IDX_MEM_PRIORITY: qos_q <= pwdata[3:0];
        `USBDLP_IDX_DEVICE_CONTROL: begin
          detach_q <= pwdata[`USBDLP_DC_DETACH];
          hsk_q <= pwdata[`USBDLP_DC_HSK_LSB+1:`USBDLP_DC_HSK_LSB];
        end
        `USBDLP_IDX_IRQ_ENABLE_CLR: irq_en_q <= irq_en_q & ~pwdata[4:0];
        `USBDLP_IDX_IRQ_ENABLE_SET: irq_en_q <= irq_en_q | pwdata[4:0];
        `USBDLP_IDX_DESC_BASE: desc_base_q <= {pwdata[31:2], 2'h0};
        `USBDLP_IDX_PAD_TRIM: pad_trim_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // endpoint halves: out type, in type, out size, in size per number
  genvar e;
  generate
    for (e = 0; e < 8; e = e + 1) begin : g_ep
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          ep_cfg_q[e] <= 16'h0000;
        end else if (soft_clr) begin
          ep_cfg_q[e] <= 16'h0000;
        end else if (wr && idx == `USBDLP_IDX_EP_CFG + e) begin
          ep_cfg_q[e] <= pwdata[15:0] & 16'h7777;
        end
      end
      assign ep_cfg_flat[e*16+15:e*16] = ep_cfg_q[e];
    end
  endgenerate

  // enable carried into the core over two stages
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_mid_q <= 1'b0;
      en_core_q <= 1'b0;
    end else begin
      en_mid_q <= enable_q;
      en_core_q <= en_mid_q;
    end
  end

  // ------------------------------------------------------------
  // bus activity and lpm decode
  // ------------------------------------------------------------
  // cycles of continuous idle line, saturating
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idle_cnt_q <= 20'h0_0000;
    end else if (~idle_s || state_q == ST_UPRESUME) begin
      idle_cnt_q <= 20'h0_0000;
    end else if (idle_cnt_q != 20'hF_FFFF) begin
      idle_cnt_q <= idle_cnt_q + 20'h0_0001;
    end
  end

  assign lpm_ep_on = |ep_cfg_q[lpm_rx_ep][6:0];
  assign lpm_take = lpm_rx_valid & lpm_ep_on & (state_q == ST_ON);
  assign lpm_ack = lpm_take & (hsk_q == `USBDLP_HSK_ACK);
  assign lpm_nyet = lpm_take & (hsk_q == `USBDLP_HSK_NYET);
  assign lpm_hs_code = lpm_take ? hsk_q : `USBDLP_HSK_NONE;
  assign lpm_hs_valid = lpm_rx_valid;

  // ------------------------------------------------------------
  // link state machine
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    set_susp = 1'b0;
    set_wake = 1'b0;
    clr_susp = 1'b0;
    set_end_of_resume_flag = 1'b0;
    rwr_done = 1'b0;
    tmr_load = 1'b0;
    tmr_val = LPM_DELAY;
    if (~en_core_q || detach_q) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: state_d = ST_ON;
        ST_ON: begin
          if (rst_s) begin
            state_d = ST_RESET;
          end else if (lpm_wait_q && tmr_done) begin
            state_d = ST_SLEEP;
          end else if (idle_cnt_q == SUSPEND_CYCLES[19:0]) begin
            state_d = ST_SUSPEND;
            set_susp = 1'b1;
          end
          if (lpm_ack) begin
            tmr_load = 1'b1;
          end
        end
        ST_RESET: begin
          if (~rst_s) begin
            state_d = ST_ON;
          end
        end
        ST_SUSPEND, ST_SLEEP: begin
          if (~idle_s) begin
            state_d = ST_DNRESUME;
            set_wake = 1'b1;
          end else if (rwr_q && (flags_q[`USBDLP_F_SUSPEND] || state_q == ST_SLEEP) &&
                       idle_cnt_q >= RWK_IDLE_CYCLES[19:0]) begin
            state_d = ST_UPRESUME;
            set_wake = 1'b1;
            clr_susp = 1'b1;
            tmr_load = 1'b1;
            tmr_val = (state_q == ST_SLEEP) ? LPM_DRIVE_CYCLES[19:0] :
                      RESUME_DRIVE_CYCLES[19:0];
          end
        end
        ST_UPRESUME: begin
          if (tmr_done) begin
            state_d = ST_DNRESUME;
            rwr_done = 1'b1;
          end
        end
        ST_DNRESUME: begin
          if (idle_s) begin
            state_d = ST_ON;
            set_end_of_resume_flag = 1'b1;
          end
        end
        default: state_d = ST_OFF;
      endcase
    end
  end

  // state and the pending lpm suspend
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_OFF;
      lpm_wait_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (lpm_ack) begin
        lpm_wait_q <= 1'b1;
      end else if (tmr_done || state_q != ST_ON) begin
        lpm_wait_q <= 1'b0;
      end
    end
  end

  // remote wake request: hardware clears at end or when ignored
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rwr_q <= 1'b0;
    end else if (soft_clr || rwr_done || state_q == ST_DNRESUME || state_q == ST_OFF) begin
      rwr_q <= 1'b0;
    end else if (rwr_wr) begin
      rwr_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // flags, interrupt and descriptor write
  // ------------------------------------------------------------
  assign hw_set = {lpm_nyet, lpm_ack, set_end_of_resume_flag, set_wake, set_susp};

  // sticky flags, hardware set wins over software clear
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flags_q <= 5'h00;
    end else if (soft_clr) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (flags_q & ~w1c & ~{4'h0, clr_susp}) | hw_set;
    end
  end

  assign irq = |(flags_q & irq_en_q);

  // link power word into bank 0 of the addressed descriptor
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      desc_wr_valid <= 1'b0;
      desc_wr_addr <= 32'h0000_0000;
      desc_wr_data <= 16'h0000;
    end else if (lpm_ack || lpm_nyet) begin
      desc_wr_valid <= 1'b1;
      desc_wr_addr <= desc_base_q + ({29'h0000_0000, lpm_rx_ep} << `USBDLP_DESC_EP_STRIDE_SH) +
                      `USBDLP_DESC_LPW_OFFSET;
      desc_wr_data <= {7'h00, lpm_rx_remote_wake, lpm_rx_besl, lpm_rx_link_state};
    end else if (desc_wr_ready) begin
      desc_wr_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pad and line outputs
  // ------------------------------------------------------------
  assign pad_active = (state_q == ST_ON) || (state_q == ST_RESET) ||
                      (state_q == ST_DNRESUME) || (state_q == ST_UPRESUME);
  assign resume_k_oe = (state_q == ST_UPRESUME);
  assign resume_k_o = (state_q == ST_UPRESUME);
  // raw pin path, needs no clock to raise a wake
  assign wake_async = ((state_q == ST_SUSPEND) || (state_q == ST_SLEEP)) & ~bus_idle_pin;
  assign core_enable = en_core_q;
  assign keep_running_asleep = keep_run_q;
  assign mem_priority = qos_q;
  assign pad_trim = pad_trim_q;
endmodule

// ### test/usbdlp_link_pm_chk.sv
/* port assertions for the link power block.
   bound to every usbdlp_link_pm instance; one clock, async reset. */
`timescale 1ns/1ps
module usbdlp_link_pm_chk (
  input wire ref_clk, // clock
  input wire reset, // async reset
  input wire lpm_rx_valid, // lpm token
  input wire [1:0] lpm_hs_code, // handshake
  input wire lpm_hs_valid, // code applies
  input wire desc_wr_valid, // write request
  input wire desc_wr_ready, // write taken
  input wire [31:0] desc_wr_addr, // write address
  input wire pad_active, // pad on
  input wire resume_k_oe, // k drive
  input wire resume_k_o, // k level
  input wire bus_idle_pin, // line idle
  input wire wake_async, // wake request
  input wire core_enable // crossed enable
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_tok; lpm_rx_valid && !desc_wr_valid; endsequence
  sequence s_ack; s_tok ##0 lpm_hs_code == 2'h1; endsequence
  sequence s_ans; s_tok ##0 (lpm_hs_code == 2'h1 || lpm_hs_code == 2'h2); endsequence
  sequence s_ign; s_tok ##0 (lpm_hs_code == 2'h0 || lpm_hs_code == 2'h3); endsequence
  property p_hsv; lpm_rx_valid |-> lpm_hs_valid; endproperty
  property p_ans; s_ans |=> desc_wr_valid; endproperty
  property p_ign; s_ign |=> !desc_wr_valid; endproperty
  property p_hold; desc_wr_valid && !desc_wr_ready |=> desc_wr_valid && $stable(desc_wr_addr);
  endproperty
  property p_kpad; resume_k_oe |-> pad_active && resume_k_o; endproperty
  property p_kmin; $rose(resume_k_oe) |-> resume_k_oe [*8]; endproperty
  property p_wake; wake_async |-> !bus_idle_pin; endproperty
  property p_off; !core_enable |=> !pad_active; endproperty
  property p_delay; s_ack |=> pad_active [*8]; endproperty
  a_hsv: assert property (p_hsv) else $error("handshake not valid");
  a_ans: assert property (p_ans) else $error("no descriptor write");
  a_ign: assert property (p_ign) else $error("ignored token wrote");
  a_hold: assert property (p_hold) else $error("write dropped");
  a_kpad: assert property (p_kpad) else $error("resume on idle pad");
  a_kmin: assert property (p_kmin) else $error("resume too short");
  a_wake: assert property (p_wake) else $error("wake on idle line");
  a_off: assert property (p_off) else $error("pad on while disabled");
  a_delay: assert property (p_delay) else $error("early suspend");
endmodule
bind usbdlp_link_pm usbdlp_link_pm_chk usbdlp_link_pm_chk_i (.ref_clk, .reset, .lpm_rx_valid,
  .lpm_hs_code, .lpm_hs_valid, .desc_wr_valid, .desc_wr_ready, .desc_wr_addr, .pad_active,
  .resume_k_oe, .resume_k_o, .bus_idle_pin, .wake_async, .core_enable);

// ### test/usbdlp_host_mdl.sv
/* upstream host and descriptor memory model.
   the bench sets line_idle_q and lag_q; got_* hold the last write. */
`timescale 1ns/1ps
module usbdlp_host_mdl (
  input wire ref_clk, // clock
  input wire resume_k_oe, // device drives k
  input wire desc_wr_valid, // write request
  input wire [31:0] desc_wr_addr, // write address
  input wire [15:0] desc_wr_data, // write data
  output reg desc_wr_ready = 1'b0, // write taken
  output wire bus_idle_pin // line idle
);
  // ----------
  // host line and memory
  // ----------
  reg line_idle_q = 1'b0; // host idles the line
  integer lag_q = 0; // memory answer delay
  integer wait_q = 0; // cycles waited
  integer echo_q = 0; // host echo of resume
  reg [31:0] got_addr = 0; // last address
  reg [15:0] got_data = 0; // last word
  // line is not idle while the host echoes a device resume
  assign bus_idle_pin = line_idle_q && echo_q == 0;
  // echo a few cycles past the device drive, then answer writes
  always @(posedge ref_clk) begin
    echo_q <= resume_k_oe ? 6 : (echo_q > 0 ? echo_q - 1 : 0);
    if (desc_wr_valid && desc_wr_ready) begin
      got_addr <= desc_wr_addr;
      got_data <= desc_wr_data;
      wait_q <= 0;
    end else if (desc_wr_valid)
      wait_q <= wait_q + 1;
    desc_wr_ready <= desc_wr_valid && !desc_wr_ready && wait_q >= lag_q;
  end
endmodule

// ### test/usbdlp_link_pm_tb.sv
/* self-checking bench for the link power block.
   drives apb and lpm tokens; usbdlp_host_mdl plays host and memory. */
`timescale 1ns/1ps
module usbdlp_link_pm_tb;
  // ----------
  // signals and instances
  // ----------
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lpm_rx_valid = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 0;
  reg [2:0] lpm_rx_ep = 3'h0;
  reg [3:0] lpm_rx_besl = 4'h0, lpm_rx_link_state = 4'h0;
  reg lpm_rx_remote_wake = 1'b0;
  wire [31:0] prdata, desc_wr_addr;
  wire [15:0] desc_wr_data;
  wire [1:0] lpm_hs_code;
  wire pready, pslverr, desc_wr_valid, desc_wr_ready, pad_active, resume_k_oe, irq;
  wire bus_idle_pin;
  integer n_fail = 0, total_checks = 0, n;
  logic [31:0] r;
  logic perr;
  logic [1:0] hc [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  // clock
  always #5 ref_clk = ~ref_clk;
  usbdlp_link_pm #(.SUSPEND_CYCLES(2000), .RWK_IDLE_CYCLES(2100), .RESUME_DRIVE_CYCLES(20),
    .LPM_DRIVE_CYCLES(10)) usbdlp_link_pm_i (.ref_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_idle_pin, .bus_reset_pin(1'b0),
    .lpm_rx_valid, .lpm_rx_ep, .lpm_rx_besl, .lpm_rx_remote_wake, .lpm_rx_link_state,
    .lpm_hs_code, .lpm_hs_valid(), .desc_wr_valid, .desc_wr_addr, .desc_wr_data,
    .desc_wr_ready, .pad_active, .resume_k_o(), .resume_k_oe, .wake_async(), .irq,
    .core_enable(), .keep_running_asleep(), .mem_priority(), .pad_trim(), .ep_cfg_flat());
  usbdlp_host_mdl host_i (.ref_clk, .resume_k_oe, .desc_wr_valid, .desc_wr_addr,
    .desc_wr_data, .desc_wr_ready, .bus_idle_pin);
  // verdict and comparison
  task complete_run;
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    cmp(r, {16'h0000, e});
  endtask
  // wait for pad (s=0) or k drive (s=1) to reach v; n counts cycles
  task wt(input logic s, input logic v, input integer lim);
    n = 0;
    while ((s ? resume_k_oe : pad_active) !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_reset;
    rd(12'h00C, 16'h000F);
    rd(12'h020, 16'h0001);
    rd(12'h034, 16'h0001);
    apb(1'b0, 12'h004, 16'h0000);
    cmp(perr, 1);
  endtask
  task t_enable;
    apb(1'b1, 12'h000, 16'h0002);
    rd(12'h008, 16'h0002);
    rd(12'h000, 16'h0002);
    repeat (3) @(posedge ref_clk);
    rd(12'h008, 16'h0000);
    apb(1'b1, 12'h020, 16'h0000);
    wt(0, 1, 20);
    rd(12'h034, 16'h0002);
  endtask
  task t_suspend;
    host_i.line_idle_q <= 1'b1;
    wt(0, 0, 3000);
    rd(12'h034, 16'h0004);
    rd(12'h070, 16'h0001);
    apb(1'b1, 12'h020, 16'h0002);
    wt(1, 1, 3000);
    wt(1, 0, 100);
    cmp(n >= 20 && n <= 21, 1);
    rd(12'h020, 16'h0000);
    repeat (20) @(posedge ref_clk);
    rd(12'h070, 16'h0006);
    apb(1'b1, 12'h070, 16'h001F);
    rd(12'h070, 16'h0000);
  endtask
  task t_host_wake;
    wt(0, 0, 3000);
    host_i.line_idle_q <= 1'b0;
    wt(0, 1, 50);
    rd(12'h034, 16'h0010);
    rd(12'h070, 16'h0003);
    apb(1'b1, 12'h020, 16'h0002);
    rd(12'h020, 16'h0000);
    cmp(resume_k_oe, 0);
    host_i.line_idle_q <= 1'b1;
    repeat (10) @(posedge ref_clk);
    apb(1'b1, 12'h070, 16'h001F);
  endtask
  task t_lpm;
    lpm_rx_ep <= 3'h1;
    lpm_rx_besl <= 4'h5;
    lpm_rx_remote_wake <= 1'b1;
    lpm_rx_link_state <= 4'h1;
    apb(1'b1, 12'h104, 16'h3631);
    rd(12'h104, 16'h3631);
    apb(1'b1, 12'h090, 16'h2000);
    apb(1'b1, 12'h058, 16'h0010);
    for (int i = 0; i < 4; i++) begin
      host_i.got_addr <= 0;
      host_i.got_data <= 0;
      host_i.lag_q <= i;
      apb(1'b1, 12'h020, {12'h000, hc[i], 2'b00});
      lpm_rx_valid <= 1'b1;
      @(posedge ref_clk);
      cmp(lpm_hs_code, hc[i]);
      lpm_rx_valid <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(12'h070, {hc[i] == 2'h2, hc[i] == 2'h1, 3'b000});
      cmp(irq, hc[i] == 2'h2);
      cmp(host_i.got_addr, (hc[i] == 2'h1 || hc[i] == 2'h2) ? 32'h0000_2028 : 0);
      cmp(host_i.got_data, (hc[i] == 2'h1 || hc[i] == 2'h2) ? 16'h0151 : 0);
      if (hc[i] != 2'h1)
        apb(1'b1, 12'h070, 16'h001F);
    end
    wt(0, 0, 1000);
    cmp(n + 11 >= 890 && n + 11 <= 910, 1);
    rd(12'h034, 16'h0008);
    apb(1'b1, 12'h020, 16'h0002);
    wt(1, 1, 3000);
    wt(1, 0, 100);
    cmp(n >= 10 && n <= 11, 1);
    apb(1'b1, 12'h020, 16'h0001);
    wt(0, 0, 40);
    cmp(pad_active, 0);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_enable;
    t_suspend;
    t_host_wake;
    t_lpm;
    complete_run;
  end
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    complete_run;
  end
endmodule
